//--- secl_config_loader.sv
`default_nettype none
// What this block does
// - primary strap level: fetch configuration from eeprom as bus master
// - successful fetch in primary mode pulls load-complete output low
// - primary mode still answers as bus target before, during, after fetch
// - secondary strap level: no fetch; external master writes configuration
// - mode strap sampled at power-up and followed while running
// - load-complete released unless loaded; released in secondary mode
// - primary mode: low load request starts the fetch
// - high-speed path disabled for the whole fetch
// - secondary mode ignores the load request input
// - four power-down inputs, each owning four lanes
// - target address comes from four five-level address straps
module secl_config_loader (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // straps, five-level values 0..4
    input wire logic [2:0] mode_strap_in,
    input wire logic [2:0] dir_a_addr_strap0_in,
    input wire logic [2:0] dir_a_addr_strap1_in,
    input wire logic [2:0] dir_b_addr_strap0_in,
    input wire logic [2:0] dir_b_addr_strap1_in,
    // control pins
    input wire logic load_req_n_in,
    input wire logic [secl_pkg::NGROUP-1:0] powerdown_group_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n_out,
    output logic sda_out,
    output logic sda_oe_n_out,
    // load complete, open drain
    output logic done_n_out,
    output logic done_oe_n_out,
    // datapath control
    output logic path_enable_out,
    output logic [15:0] lane_pd_out,
    output logic [secl_pkg::NREG*8-1:0] cfg_image_out
);
    import secl_pkg::*;
    localparam int SW = 22;
    localparam int NF = NGROUP + 1;

    function automatic logic [6:0] strap_addr(input logic [6:0] base,
            input logic [2:0] s1, input logic [2:0] s0);
        return base + 7'({4'h0, s1} * 7'h05) + {4'h0, s0};
    endfunction

    // ==========================================
    // synchronisers, every pin passes two flops
    logic [SW-1:0] raw, sync1, sync2;
    logic sc_d, sd_d;
    assign raw = {scl_in, sda_in, load_req_n_in, powerdown_group_in,
        mode_strap_in, dir_a_addr_strap1_in, dir_a_addr_strap0_in,
        dir_b_addr_strap1_in, dir_b_addr_strap0_in};
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // bus lines and request idle high: no false edge out of reset
            sync1 <= {3'b111, {(SW-3){1'b0}}};
            sync2 <= {3'b111, {(SW-3){1'b0}}};
            sc_d <= 1'b1;
            sd_d <= 1'b1;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sc_d <= sync2[21];
            sd_d <= sync2[20];
        end
    end
    logic sc, sd, primary, secondary;
    logic [6:0] addr_a, addr_b;
    assign sc = sync2[21];
    assign sd = sync2[20];
    // strap followed live, no latch at power-up only
    assign primary = sync2[14:12] == LVL_PRIMARY;
    assign secondary = sync2[14:12] == LVL_SECONDARY;
    assign addr_a = strap_addr(ADDR_BASE_A, sync2[11:9], sync2[8:6]);
    assign addr_b = strap_addr(ADDR_BASE_B, sync2[5:3], sync2[2:0]);

    // ==========================================
    // pulse-width filters: request and power-down
    logic [NF-1:0] flt_raw, filt;
    assign flt_raw = sync2[19:15];
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_flt
            logic [FLT_W-1:0] cnt, next_cnt;
            logic next_filt;
            always_comb begin
                next_cnt = '0;
                next_filt = filt[gi];
                if (flt_raw[gi] != filt[gi]) begin
                    // short glitches never reach the loader
                    if (cnt == FLT_W'(PULSE_CYC - 1)) begin
                        next_filt = flt_raw[gi];
                    end else begin
                        next_cnt = cnt + FLT_W'(1);
                    end
                end
            end
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    cnt <= '0;
                    filt[gi] <= (gi == NGROUP);
                end else begin
                    cnt <= next_cnt;
                    filt[gi] <= next_filt;
                end
            end
        end
    endgenerate
    logic req_low;
    assign req_low = !filt[NGROUP];

    // ==========================================
    // eeprom reader
    logic m_scl_oe_n, m_sda_oe_n, m_wr, m_busy, m_done, m_fail;
    logic [$clog2(NREG)-1:0] m_idx;
    logic [7:0] m_data;
    secl_ld_e ld, next_ld;
    logic fetch_start;
    assign fetch_start = ld == LD_IDLE && primary && req_low;
    secl_eeprom_rd #(.QTR(SCL_QTR_CYC), .NBYTES(NREG)) u_rd (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(fetch_start),
        .abort_in(!primary),
        .scl_in(sc),
        .sda_in(sd),
        .scl_oe_n_out(m_scl_oe_n),
        .sda_oe_n_out(m_sda_oe_n),
        .wr_valid_out(m_wr),
        .wr_idx_out(m_idx),
        .wr_data_out(m_data),
        .busy_out(m_busy),
        .done_out(m_done),
        .fail_out(m_fail)
    );

    // ==========================================
    // bus target: address match, index, data writes
    secl_tgt_e ts, next_ts;
    logic [2:0] tbit, next_tbit;
    logic [1:0] tbyte, next_tbyte;
    logic [7:0] tsh, next_tsh, tidx, next_tidx;
    logic t_oe_n, next_t_oe_n, t_wr, t_ack;
    logic start_c, stop_c, rise, fall;
    assign start_c = sc && sc_d && sd_d && !sd;
    assign stop_c = sc && sc_d && !sd_d && sd;
    assign rise = sc && !sc_d;
    assign fall = !sc && sc_d;
    always_comb begin
        next_ts = ts;
        next_tbit = tbit;
        next_tbyte = tbyte;
        next_tsh = tsh;
        next_tidx = tidx;
        next_t_oe_n = t_oe_n;
        t_wr = 1'b0;
        t_ack = 1'b1;
        if (start_c) begin
            next_ts = T_RECV;
            next_tbit = 3'h0;
            next_tbyte = 2'h0;
            next_t_oe_n = 1'b1;
        end else if (stop_c) begin
            next_ts = T_IDLE;
            next_t_oe_n = 1'b1;
        end else begin
            case (ts)
                T_RECV: if (rise) begin
                    next_tsh = {tsh[6:0], sd};
                    next_tbit = tbit + 3'h1;
                    if (tbit == 3'h7) begin
                        next_ts = T_WAIT;
                    end
                end
                T_WAIT: if (fall) begin
                    // reads are not served: read address is refused
                    if (tbyte == 2'h0) begin
                        t_ack = !tsh[0] && (tsh[7:1] == addr_a
                            || tsh[7:1] == addr_b);
                    end else if (tbyte == 2'h1) begin
                        next_tidx = tsh;
                    end else begin
                        t_wr = tidx < 8'(NREG);
                        next_tidx = tidx + 8'h01;
                    end
                    next_t_oe_n = !t_ack;
                    next_ts = t_ack ? T_ACK : T_IDLE;
                end
                T_ACK: if (fall) begin
                    next_t_oe_n = 1'b1;
                    next_tbit = 3'h0;
                    next_tbyte = (tbyte == 2'h2) ? 2'h2 : tbyte + 2'h1;
                    next_ts = T_RECV;
                end
                default: next_t_oe_n = 1'b1;
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ts <= T_IDLE;
            tbit <= 3'h0;
            tbyte <= 2'h0;
            tsh <= 8'h00;
            tidx <= 8'h00;
            t_oe_n <= 1'b1;
        end else begin
            ts <= next_ts;
            tbit <= next_tbit;
            tbyte <= next_tbyte;
            tsh <= next_tsh;
            tidx <= next_tidx;
            t_oe_n <= next_t_oe_n;
        end
    end

    // ==========================================
    // load state, image and outputs
    logic [7:0] img [NREG];
    logic [7:0] next_img [NREG];
    always_comb begin
        next_ld = ld;
        next_img = img;
        case (ld)
            LD_IDLE: if (fetch_start) next_ld = LD_BUSY;
            LD_BUSY: begin
                if (!primary) begin
                    next_ld = LD_IDLE;
                end else if (m_done) begin
                    next_ld = LD_DONE;
                end else if (m_fail) begin
                    next_ld = LD_FAIL;
                end
            end
            // held request after completion changes nothing
            LD_DONE: if (!primary) next_ld = LD_IDLE;
            default: if (!primary || !req_low) next_ld = LD_IDLE;
        endcase
        // eeprom byte wins a clash with a target write
        if (t_wr) begin
            next_img[tidx[$clog2(NREG)-1:0]] = tsh;
        end
        if (m_wr && primary) begin
            next_img[m_idx] = m_data;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ld <= LD_IDLE;
            for (int i = 0; i < NREG; i++) begin
                img[i] <= 8'h00;
            end
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            done_n_out <= 1'b0;
            scl_oe_n_out <= 1'b1;
            sda_oe_n_out <= 1'b1;
            done_oe_n_out <= 1'b1;
            path_enable_out <= 1'b0;
            lane_pd_out <= 16'h0000;
            cfg_image_out <= '0;
        end else begin
            ld <= next_ld;
            img <= next_img;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            done_n_out <= 1'b0;
            scl_oe_n_out <= m_scl_oe_n;
            sda_oe_n_out <= m_sda_oe_n & t_oe_n;
            done_oe_n_out <= next_ld != LD_DONE;
            path_enable_out <= next_ld != LD_BUSY;
            for (int g = 0; g < NGROUP; g++) begin
                lane_pd_out[g*LANES_PER_GROUP +: LANES_PER_GROUP] <=
                    {LANES_PER_GROUP{filt[g]}};
            end
            for (int i = 0; i < NREG; i++) begin
                cfg_image_out[i*8 +: 8] <= next_img[i];
            end
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_done_needs_load: assert property (!done_oe_n_out |->
        $past(ld) == LD_DONE || ld == LD_DONE)
        else $error("load complete shown without a finished load");
    a_done_released: assert property (!primary ##1 !primary |->
        done_oe_n_out)
        else $error("load complete driven outside primary mode");
    a_path_off_busy: assert property (ld == LD_BUSY |-> !path_enable_out)
        else $error("signal path enabled during fetch");
    a_req_starts: assert property (ld == LD_IDLE && primary && req_low
        |=> ld == LD_BUSY ##1 m_busy)
        else $error("request did not start the fetch");
    a_no_fetch_sec: assert property (secondary |-> !fetch_start)
        else $error("fetch started in secondary mode");
    a_nack_fails: assert property (ld == LD_BUSY && primary && m_fail
        |=> ld == LD_FAIL ##1 done_oe_n_out)
        else $error("failed fetch not reported");
    a_filter_width: assert property ($changed(filt) |->
        $past(flt_raw) != $past(filt, 2))
        else $error("filtered level changed without a held input");
    a_addr_ack: assert property (ts == T_WAIT && fall && tbyte == 2'h0
        && !tsh[0] && tsh[7:1] == addr_a |=> ts == T_ACK && !t_oe_n)
        else $error("own address not acknowledged");
    a_pd_group: assert property ($rose(filt[1]) |=>
        lane_pd_out[7:4] == 4'hF)
        else $error("power-down group 1 not applied");
    c_load_done: cover property (ld == LD_BUSY ##1 ld == LD_DONE);
    c_load_fail: cover property (ld == LD_BUSY ##1 ld == LD_FAIL);
    c_tgt_write: cover property (t_wr && secondary);
    c_tgt_in_fetch: cover property (t_wr && ld == LD_BUSY);
endmodule
`default_nettype wire

//--- secl_pkg.sv
`default_nettype none
package secl_pkg;
    // ==========================================
    // strap levels and timing
    localparam logic [2:0] LVL_PRIMARY = 3'h1;
    localparam logic [2:0] LVL_SECONDARY = 3'h2;
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_US = 200;
    localparam int PULSE_CYC = (PULSE_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int FLT_W = 12;
    localparam int SCL_HZ = 100_000;
    localparam int SCL_QTR_CYC = CLK_HZ / (4 * SCL_HZ);
    // ==========================================
    // bus addresses and image
    localparam logic [6:0] EEPROM_ADDR = 7'h50;
    localparam logic [6:0] ADDR_BASE_A = 7'h18;
    localparam logic [6:0] ADDR_BASE_B = 7'h40;
    localparam logic [7:0] EEPROM_START = 8'h00;
    localparam int NREG = 8;
    localparam int NGROUP = 4;
    localparam int LANES_PER_GROUP = 4;
    typedef enum logic [1:0] {LD_IDLE, LD_BUSY, LD_DONE, LD_FAIL} secl_ld_e;
    typedef enum logic [1:0] {T_IDLE, T_RECV, T_WAIT, T_ACK} secl_tgt_e;
    typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} secl_mst_e;
endpackage
`default_nettype wire

//--- secl_eeprom_rd.sv
`default_nettype none
module secl_eeprom_rd #(
    parameter int QTR = secl_pkg::SCL_QTR_CYC,
    parameter int NBYTES = secl_pkg::NREG,
    parameter int IW = $clog2(NBYTES)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic start_in,
    input wire logic abort_in,
    // synchronised bus levels
    input wire logic scl_in,
    input wire logic sda_in,
    // bus drive, low enable pulls the line
    output logic scl_oe_n_out,
    output logic sda_oe_n_out,
    // image bytes and status
    output logic wr_valid_out,
    output logic [IW-1:0] wr_idx_out,
    output logic [7:0] wr_data_out,
    output logic busy_out,
    output logic done_out,
    output logic fail_out
);
    import secl_pkg::*;
    secl_mst_e st, next_st;
    logic [1:0] q, next_q, stage, next_stage;
    logic [7:0] div, next_div, sh, next_sh;
    logic [2:0] bitn, next_bitn;
    logic [IW-1:0] cnt, next_cnt;
    logic rx, next_rx, ok, next_ok;
    logic next_scl_oe_n, next_sda_oe_n, next_wr_valid, next_done, next_fail;
    logic [1:0] nq;

    // ==========================================
    // byte engine: start, address, word, restart, read
    always_comb begin
        next_st = st;
        next_q = q;
        next_stage = stage;
        next_div = div;
        next_sh = sh;
        next_bitn = bitn;
        next_cnt = cnt;
        next_rx = rx;
        next_ok = ok;
        next_scl_oe_n = scl_oe_n_out;
        next_sda_oe_n = sda_oe_n_out;
        next_wr_valid = 1'b0;
        next_done = 1'b0;
        next_fail = 1'b0;
        nq = q + 2'h1;
        if (abort_in && st != M_IDLE) begin
            next_st = M_IDLE;
            next_scl_oe_n = 1'b1;
            next_sda_oe_n = 1'b1;
        end else if (st == M_IDLE) begin
            next_scl_oe_n = 1'b1;
            next_sda_oe_n = 1'b1;
            if (start_in) begin
                next_st = M_START;
                next_q = 2'h0;
                next_div = 8'h00;
                next_stage = 2'h0;
                next_ok = 1'b0;
            end
        end else if (div != 8'(QTR - 1)) begin
            next_div = div + 8'h01;
        end else begin
            next_div = 8'h00;
            next_q = nq;
            if (nq == 2'h0) begin
                next_scl_oe_n = 1'b0;
            end
            case (st)
                M_START: begin
                    if (nq == 2'h1) begin
                        next_scl_oe_n = 1'b1;
                    end else if (nq == 2'h2) begin
                        next_sda_oe_n = 1'b0;
                    end else if (nq == 2'h0) begin
                        next_st = M_BIT;
                        next_bitn = 3'h0;
                        next_rx = 1'b0;
                        next_sh = {EEPROM_ADDR, stage != 2'h0};
                    end
                end
                M_BIT: begin
                    if (nq == 2'h1) begin
                        next_sda_oe_n = rx | sh[7];
                    end else if (nq == 2'h2) begin
                        next_scl_oe_n = 1'b1;
                    end else if (nq == 2'h3) begin
                        next_sh = {sh[6:0], sda_in};
                        // lost arbitration: release the bus and flag a failed fetch
                        if (!rx && sda_oe_n_out && !sda_in) begin
                            next_st = M_IDLE;
                            next_scl_oe_n = 1'b1;
                            next_fail = 1'b1;
                        end
                    end else begin
                        next_bitn = bitn + 3'h1;
                        if (bitn == 3'h7) begin
                            next_st = M_ACK;
                        end
                    end
                end
                M_ACK: begin
                    if (nq == 2'h1) begin
                        next_sda_oe_n = !rx || cnt == IW'(NBYTES - 1);
                    end else if (nq == 2'h2) begin
                        next_scl_oe_n = 1'b1;
                    end else if (nq == 2'h3) begin
                        // keep the ack level so a nack still ends in a stop
                        next_sh = rx ? sh : {sh[6:0], sda_in};
                        next_wr_valid = rx;
                    end else if (!rx && sh[0]) begin
                        next_st = M_STOP;
                    end else if (stage == 2'h0) begin
                        next_st = M_BIT;
                        next_stage = 2'h1;
                        next_sh = EEPROM_START;
                    end else if (stage == 2'h1) begin
                        next_st = M_START;
                        next_stage = 2'h2;
                        next_sda_oe_n = 1'b1;
                    end else if (stage == 2'h2) begin
                        next_st = M_BIT;
                        next_stage = 2'h3;
                        next_rx = 1'b1;
                        next_cnt = '0;
                    end else if (cnt == IW'(NBYTES - 1)) begin
                        next_st = M_STOP;
                        next_ok = 1'b1;
                    end else begin
                        next_st = M_BIT;
                        next_cnt = cnt + IW'(1);
                    end
                end
                M_STOP: begin
                    if (nq == 2'h1) begin
                        next_sda_oe_n = 1'b0;
                    end else if (nq == 2'h2) begin
                        next_scl_oe_n = 1'b1;
                    end else if (nq == 2'h3) begin
                        next_sda_oe_n = 1'b1;
                    end else begin
                        next_scl_oe_n = 1'b1;
                        next_st = M_IDLE;
                        next_done = ok;
                        next_fail = !ok;
                    end
                end
                default: next_st = M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= M_IDLE;
            q <= 2'h0;
            stage <= 2'h0;
            div <= 8'h00;
            sh <= 8'h00;
            bitn <= 3'h0;
            cnt <= '0;
            rx <= 1'b0;
            ok <= 1'b0;
            scl_oe_n_out <= 1'b1;
            sda_oe_n_out <= 1'b1;
            wr_valid_out <= 1'b0;
            wr_idx_out <= '0;
            wr_data_out <= 8'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            fail_out <= 1'b0;
        end else begin
            st <= next_st;
            q <= next_q;
            stage <= next_stage;
            div <= next_div;
            sh <= next_sh;
            bitn <= next_bitn;
            cnt <= next_cnt;
            rx <= next_rx;
            ok <= next_ok;
            scl_oe_n_out <= next_scl_oe_n;
            sda_oe_n_out <= next_sda_oe_n;
            wr_valid_out <= next_wr_valid;
            wr_idx_out <= cnt;
            wr_data_out <= sh;
            busy_out <= next_st != M_IDLE;
            done_out <= next_done;
            fail_out <= next_fail;
        end
    end
endmodule
`default_nettype wire

//--- secl_eeprom_model.sv
`default_nettype none
module secl_eeprom_model (
    // wired bus levels
    input wire logic scl_in,
    input wire logic sda_in,
    // fault: refuse every address
    input wire logic refuse_in,
    // open drain, low pulls sda
    output logic sda_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import secl_pkg::*;
    // ==========================================
    // behavioural store answering plain reads
    logic [7:0] mem [NREG];
    logic [7:0] sh;
    logic [7:0] ptr;
    int ph;
    int cnt;
    initial begin
        sda_oe_n_out = 1'b1;
        ph = 0;
        cnt = 0;
        ptr = 8'h00;
        for (int k = 0; k < NREG; k++) mem[k] = 8'h81 + 8'(k) * 8'h13;
    end
    always @(negedge sda_in) if (scl_in === 1'b1) begin
        ph = 1;
        cnt = 0;
    end
    always @(posedge sda_in) if (scl_in === 1'b1) ph = 0;
    always @(posedge scl_in) begin
        if (ph == 3 && cnt == 8) begin
            // master nack ends the read
            if (sda_in !== 1'b0) ph = 0;
            cnt = 9;
        end else if (ph == 3) cnt++;
        else if (ph != 0 && cnt < 8) begin
            sh = {sh[6:0], sda_in};
            cnt++;
        end
    end
    always @(negedge scl_in) begin
        if (ph inside {1, 2} && cnt == 9) begin
            cnt = 0;
            if (ph == 2) ptr = sh;
            else ph = sh[0] ? 3 : 2;
        end else if (ph inside {1, 2} && cnt == 8) begin
            if (ph == 1 && (sh[7:1] !== EEPROM_ADDR || refuse_in)) ph = 0;
            else cnt = 9;
        end else if (ph == 3 && cnt == 9) begin
            cnt = 0;
            ptr = ptr + 8'h01;
        end
        if (ph == 3) sda_oe_n_out = (cnt < 8) ? mem[ptr % NREG][7 - cnt] : 1'b1;
        else sda_oe_n_out = !(ph inside {1, 2} && cnt == 9);
    end
endmodule
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import secl_pkg::*;
    // ==========================================
    // pins and wired-and bus with pull-ups
    logic clk_in, rst_in, load_req_n, refuse, m_scl_oe_n, m_sda_oe_n, ok;
    logic [2:0] mode;
    logic [3:0] pd;
    logic scl_oe_n, sda_oe_n, ee_sda_oe_n, done_oe_n, path_en;
    logic scl_zero, sda_zero, done_zero;
    logic [15:0] lane_pd;
    logic [NREG*8-1:0] image;
    wire logic scl = scl_oe_n & m_scl_oe_n;
    wire logic sda = sda_oe_n & m_sda_oe_n & ee_sda_oe_n;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    secl_config_loader dut (.clk_in(clk_in), .rst_in(rst_in),
        .mode_strap_in(mode), .dir_a_addr_strap0_in(3'h3),
        .dir_a_addr_strap1_in(3'h2), .dir_b_addr_strap0_in(3'h4),
        .dir_b_addr_strap1_in(3'h1), .load_req_n_in(load_req_n),
        .powerdown_group_in(pd), .scl_in(scl), .sda_in(sda),
        .scl_out(scl_zero), .scl_oe_n_out(scl_oe_n), .sda_out(sda_zero),
        .sda_oe_n_out(sda_oe_n), .done_n_out(done_zero),
        .done_oe_n_out(done_oe_n),
        .path_enable_out(path_en), .lane_pd_out(lane_pd),
        .cfg_image_out(image));
    secl_eeprom_model eeprom (.scl_in(scl), .sda_in(sda),
        .refuse_in(refuse), .sda_oe_n_out(ee_sda_oe_n));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // ==========================================
    // shared tasks
    task automatic results();
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            $display("ERROR %0t timeout", $time);
            results();
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic bus_wait(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // one bit at 800 ns per clock; level sampled late in the high phase
    task automatic mst_bit(input logic b, output logic r);
        bus_wait(2);
        m_sda_oe_n <= b;
        bus_wait(2);
        m_scl_oe_n <= 1'b1;
        bus_wait(4);
        r = sda;
        m_scl_oe_n <= 1'b0;
    endtask
    task automatic mst_write(input logic [6:0] a, input logic [7:0] idx,
                             input logic [7:0] dat, output logic ack);
        logic [23:0] s;
        logic r;
        s = {a, 1'b0, idx, dat};
        ack = 1'b1;
        m_sda_oe_n <= 1'b0;
        bus_wait(4);
        m_scl_oe_n <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            mst_bit(s[23-i], r);
            if (i % 8 == 7) mst_bit(1'b1, r);
            if (i % 8 == 7) ack = ack & (r === 1'b0);
        end
        // stop: data low under a low clock, clock up, then data up
        bus_wait(2);
        m_sda_oe_n <= 1'b0;
        bus_wait(2);
        m_scl_oe_n <= 1'b1;
        bus_wait(4);
        m_sda_oe_n <= 1'b1;
        bus_wait(8);
    endtask
    // ==========================================
    // scenarios
    task automatic t_powerdown();
        pd <= 4'h2;
        bus_wait(1000);
        pd <= 4'h0;
        bus_wait(2100);
        check(lane_pd, 64'h0, "short pulse");
        pd <= 4'h4;
        bus_wait(2100);
        check(lane_pd, 64'h0F00, "group two");
        pd <= 4'h9;
        bus_wait(2100);
        check(lane_pd, 64'hF00F, "groups zero three");
    endtask
    task automatic t_secondary();
        load_req_n <= 1'b0;
        bus_wait(2500);
        check(path_en, 64'h1, "request ignored");
        check(done_oe_n, 64'h1, "done released");
        mst_write(ADDR_BASE_A + 7'h0D, 8'h00, 8'hA5, ok);
        check(ok, 64'h1, "addr a ack");
        mst_write(ADDR_BASE_B + 7'h09, 8'h07, 8'h3C, ok);
        check(ok, 64'h1, "addr b ack");
        mst_write(ADDR_BASE_A + 7'h0E, 8'h02, 8'h77, ok);
        check(ok, 64'h0, "other addr nack");
        check(image, 64'h3C00_0000_0000_00A5, "written image");
    endtask
    task automatic t_fetch();
        logic [63:0] exp;
        int bad;
        bad = 0;
        for (int k = 0; k < NREG; k++) exp[8*k+:8] = 8'h81 + 8'(k) * 8'h13;
        mode <= LVL_PRIMARY;
        for (int i = 0; i < 100 && path_en !== 1'b0; i++) bus_wait(1);
        check(path_en, 64'h0, "fetch started");
        for (int i = 0; i < 20000 && done_oe_n !== 1'b0; i++) begin
            bus_wait(1);
            if (path_en !== 1'b0 && done_oe_n !== 1'b0) bad++;
        end
        check(bad, 64'h0, "path off in fetch");
        check(done_oe_n, 64'h0, "done low");
        bus_wait(5);
        check(image, exp, "fetched image");
        bus_wait(500);
        check(done_oe_n, 64'h0, "held request");
        check(path_en, 64'h1, "path back");
        mst_write(ADDR_BASE_A + 7'h0D, 8'h01, 8'h5A, ok);
        check(ok, 64'h1, "target in primary");
        check(image[15:8], 64'h5A, "target byte");
    endtask
    task automatic t_fail();
        refuse <= 1'b1;
        mode <= LVL_SECONDARY;
        bus_wait(20);
        check(done_oe_n, 64'h1, "secondary released");
        mode <= LVL_PRIMARY;
        for (int i = 0; i < 100 && path_en !== 1'b0; i++) bus_wait(1);
        check(path_en, 64'h0, "strap change");
        for (int i = 0; i < 5000 && path_en !== 1'b1; i++) bus_wait(1);
        check(path_en, 64'h1, "nack ends fetch");
        check(done_oe_n, 64'h1, "failed load");
        check({scl_zero, sda_zero, done_zero}, 64'h0, "drive levels");
    endtask
    initial begin
        rst_in = 1'b1;
        mode = LVL_SECONDARY;
        load_req_n = 1'b1;
        pd = 4'h0;
        refuse = 1'b0;
        m_scl_oe_n = 1'b1;
        m_sda_oe_n = 1'b1;
        bus_wait(20);
        rst_in <= 1'b0;
        bus_wait(5);
        check(done_oe_n, 64'h1, "done after reset");
        check(lane_pd, 64'h0, "lanes after reset");
        t_powerdown();
        t_secondary();
        t_fetch();
        t_fail();
        results();
    end
endmodule
`default_nettype wire
